// [include/pie_pkg.sv]
// Constants for the partial instruction executor.
// Assumes a 14-bit instruction word, 8-bit data and a 13-bit program counter.
`default_nettype none
package pie_pkg;
    localparam int INSN_W  = 14;
    localparam int DATA_W  = 8;
    localparam int PC_W    = 13;
    localparam int ADDR_W  = 7;
    localparam int BIT_W   = 3;
    localparam int STACK_D = 8;
    localparam int SP_W    = 3;
    // Opcode patterns and masks.
    localparam logic [13:0] OP_BTSS_MASK = 14'h3C00;
    localparam logic [13:0] OP_BTSS_VAL  = 14'h1C00;
    localparam logic [13:0] OP_CALL_MASK = 14'h3800;
    localparam logic [13:0] OP_CALL_VAL  = 14'h2000;
    localparam logic [13:0] OP_CLEAR_MASK = 14'h3F80;
    localparam logic [13:0] OP_CLEAR_VAL  = 14'h0180;
    localparam logic [13:0] OP_MOVE_MASK  = 14'h3F00;
    localparam logic [13:0] OP_MOVE_VAL   = 14'h0800;
    localparam logic [13:0] OP_MOVW_MASK = 14'h3F80;
    localparam logic [13:0] OP_MOVW_VAL  = 14'h0080;
    localparam logic [13:0] OP_NOP_MASK  = 14'h3F9F;
    localparam logic [13:0] OP_NOP_VAL   = 14'h0000;
    localparam logic [13:0] OP_LDOPT     = 14'h0062;
    // Field positions.
    localparam int DEST_BIT  = 7;
    localparam int BSEL_LSB  = 7;
    localparam int CALL_W    = 11;
    localparam int LATCH_LSB = 3;
    // Reset values and the interrupt vector.
    localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
    localparam logic [PC_W-1:0]   ISR_VEC   = 13'h0004;
    localparam logic [DATA_W-1:0] OPT_RESET = 8'hFF;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [SP_W-1:0]   SP_RESET  = 3'h0;
    typedef enum logic [1:0] {
        PIE_EXEC,
        PIE_FLUSH
    } pie_state_t;
endpackage
`default_nettype wire

// [rtl/pie_stack.sv]
// Return-address stack, a circular array of program counter values.
// Assumes one push or one pop at most per cycle.
`timescale 1ns/10ps
`default_nettype none
module pie_stack (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       reset,
    // Stack operations
    input  wire logic                       push,
    input  wire logic                       pop,
    input  wire logic [pie_pkg::PC_W-1:0]   push_value,
    output logic      [pie_pkg::PC_W-1:0]   top_of_stack_entry
);
    logic [pie_pkg::PC_W-1:0] entries [pie_pkg::STACK_D];
    logic [pie_pkg::SP_W-1:0] sp;

    // Overflow wraps silently, matching a small hardware stack.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sp <= pie_pkg::SP_RESET;
        end else if (push) begin
            sp <= sp + 3'h1;
        end else if (pop) begin
            sp <= sp - 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            entries[sp] <= push_value;
        end
    end

    assign top_of_stack_entry = entries[sp - 3'h1];
endmodule
`default_nettype wire

// [rtl/pie_core.sv]
// Executes a subset of the 14-bit instruction set, one instruction a cycle.
// Assumes the fetch path presents a word with insn_valid and that the file
// register read data for insn_word's address is available combinationally.
`timescale 1ns/10ps
`default_nettype none
module pie_core (
    // Clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           reset,
    // Instruction fetch
    input  wire logic                           insn_valid,
    input  wire logic [pie_pkg::INSN_W-1:0]     insn_word,
    input  wire logic                           irq_request,
    input  wire logic [pie_pkg::DATA_W-1:0]     program_counter_high_latch,
    // File register port
    input  wire logic [pie_pkg::DATA_W-1:0]     file_rdata,
    output logic      [pie_pkg::ADDR_W-1:0]     file_addr,
    output logic      [pie_pkg::DATA_W-1:0]     file_wdata,
    output logic                                file_we,
    // Core state
    output logic      [pie_pkg::PC_W-1:0]       program_counter,
    output logic      [pie_pkg::DATA_W-1:0]     working_accumulator,
    output logic                                zero_flag,
    output logic      [pie_pkg::DATA_W-1:0]     option_config,
    output logic      [pie_pkg::PC_W-1:0]       stack_top,
    output logic                                flushing
);
    pie_pkg::pie_state_t state;
    logic [pie_pkg::ADDR_W-1:0] f_addr;
    logic [pie_pkg::BIT_W-1:0]  bsel;
    logic is_btss, is_call, is_clear, is_move, is_movw, is_nop, is_ldopt;
    logic execute, take_irq, skip_taken, push;
    logic do_call, start_flush, write_file;
    logic [pie_pkg::PC_W-1:0] pc_plus1, call_target, ret_addr;

    assign f_addr   = insn_word[pie_pkg::ADDR_W-1:0];
    assign bsel     = insn_word[pie_pkg::BSEL_LSB +: pie_pkg::BIT_W];
    assign is_btss  = (insn_word & pie_pkg::OP_BTSS_MASK)
                      == pie_pkg::OP_BTSS_VAL;
    assign is_call  = (insn_word & pie_pkg::OP_CALL_MASK)
                      == pie_pkg::OP_CALL_VAL;
    assign is_clear = (insn_word & pie_pkg::OP_CLEAR_MASK)
                      == pie_pkg::OP_CLEAR_VAL;
    assign is_move  = (insn_word & pie_pkg::OP_MOVE_MASK)
                      == pie_pkg::OP_MOVE_VAL;
    assign is_movw  = (insn_word & pie_pkg::OP_MOVW_MASK)
                      == pie_pkg::OP_MOVW_VAL;
    assign is_nop   = (insn_word & pie_pkg::OP_NOP_MASK)
                      == pie_pkg::OP_NOP_VAL;
    assign is_ldopt = insn_word == pie_pkg::OP_LDOPT;

    // Interrupts are taken only between instructions, never in a flush cycle.
    assign execute     = insn_valid && state == pie_pkg::PIE_EXEC
                         && !irq_request;
    assign take_irq    = insn_valid && state == pie_pkg::PIE_EXEC
                         && irq_request;
    assign skip_taken  = execute && is_btss && file_rdata[bsel];
    assign do_call     = execute && is_call;
    assign start_flush = skip_taken || do_call || take_irq;
    assign pc_plus1    = program_counter + 13'h0001;
    assign call_target = {program_counter_high_latch[pie_pkg::LATCH_LSB +:
                          pie_pkg::PC_W - pie_pkg::CALL_W],
                          insn_word[pie_pkg::CALL_W-1:0]};
    // The interrupted word has not run, so its own address is the return.
    assign ret_addr    = take_irq ? program_counter : pc_plus1;
    assign push        = do_call || take_irq;
    assign write_file  = execute && (is_clear || is_movw ||
                         (is_move && insn_word[pie_pkg::DEST_BIT]));

    // Returns lie outside this subset, so only the push side is used here.
    pie_stack u_stack (
        .sys_clk            (sys_clk),
        .reset              (reset),
        .push               (push),
        .pop                (1'b0),
        .push_value         (ret_addr),
        .top_of_stack_entry ()
    );

    // A taken skip, a call or an interrupt entry spends the next cycle discarding the prefetch.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= pie_pkg::PIE_EXEC;
        end else if (state == pie_pkg::PIE_FLUSH) begin
            state <= pie_pkg::PIE_EXEC;
        end else if (start_flush) begin
            state <= pie_pkg::PIE_FLUSH;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            program_counter <= pie_pkg::PC_RESET;
        end else if (take_irq) begin
            program_counter <= pie_pkg::ISR_VEC;
        end else if (do_call) begin
            program_counter <= call_target;
        end else if (state == pie_pkg::PIE_FLUSH || execute) begin
            program_counter <= pc_plus1;
        end
    end

    // Only the return address is saved on interrupt entry.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            working_accumulator <= pie_pkg::ZERO_BYTE;
        end else if (execute && is_move && !insn_word[pie_pkg::DEST_BIT]) begin
            working_accumulator <= file_rdata;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            zero_flag <= 1'b0;
        end else if (execute && is_clear) begin
            zero_flag <= 1'b1;
        end else if (execute && is_move) begin
            zero_flag <= file_rdata == pie_pkg::ZERO_BYTE;
        end
    end

    // The legacy option load is kept only for older code.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            option_config <= pie_pkg::OPT_RESET;
        end else if (execute && is_ldopt) begin
            option_config <= working_accumulator;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            file_we <= 1'b0;
        end else begin
            file_we <= write_file;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            file_addr <= '0;
        end else begin
            file_addr <= f_addr;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            file_wdata <= pie_pkg::ZERO_BYTE;
        end else if (is_clear) begin
            file_wdata <= pie_pkg::ZERO_BYTE;
        end else if (is_movw) begin
            file_wdata <= working_accumulator;
        end else begin
            file_wdata <= file_rdata;
        end
    end

    // The stack array has no reset, so its view is the last pushed value.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stack_top <= pie_pkg::PC_RESET;
        end else if (push) begin
            stack_top <= ret_addr;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            flushing <= 1'b0;
        end else begin
            flushing <= start_flush;
        end
    end
endmodule
`default_nettype wire

// [test/pie_core_monitor.sv]
// Port assertions for the executor core, bound into every core.
// Assumes only the core's own ports are visible.
`timescale 1ns/10ps
`default_nettype none
module pie_core_monitor (
    // Clock, reset and fetch
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        insn_valid,
    input wire logic [13:0] insn_word,
    input wire logic        irq_request,
    input wire logic [7:0]  program_counter_high_latch,
    // File port and core state
    input wire logic [7:0]  file_rdata,
    input wire logic [6:0]  file_addr,
    input wire logic [7:0]  file_wdata,
    input wire logic        file_we,
    input wire logic [12:0] program_counter,
    input wire logic [7:0]  working_accumulator,
    input wire logic        zero_flag,
    input wire logic [7:0]  option_config,
    input wire logic [12:0] stack_top,
    input wire logic        flushing
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // A word in the discard cycle is never executed.
    wire logic        go = insn_valid && !flushing;
    wire logic        ex = go && !irq_request;
    wire logic [13:0] w  = insn_word;
    chk_irq_entry: assert property (go && irq_request |=>
        program_counter == 13'h0004 && stack_top == $past(program_counter)
        && $stable(working_accumulator) && $stable(zero_flag) && flushing)
        else $error("interrupt entry wrong");
    chk_skip_flush: assert property (ex && (w & 14'h3C00) == 14'h1C00 |=>
        flushing == $past(file_rdata[w[9:7]])
        && program_counter == $past(program_counter) + 13'h1)
        else $error("skip wrong");
    chk_call_jump: assert property (ex && (w & 14'h3800) == 14'h2000 |=>
        (flushing && stack_top == $past(program_counter) + 13'h1
        && program_counter == {$past(program_counter_high_latch[4:3]),
        $past(w[10:0])}) ##1 !flushing) else $error("call wrong");
    chk_clear_file: assert property (ex && (w & 14'h3F80) == 14'h0180 |=>
        file_we && file_wdata == 8'h00 && file_addr == $past(w[6:0])
        && zero_flag) else $error("clear wrong");
    chk_move_file: assert property (ex && (w & 14'h3F00) == 14'h0800 |=>
        zero_flag == ($past(file_rdata) == 8'h00) && ($past(w[7]) ?
        file_we && file_wdata == $past(file_rdata) :
        working_accumulator == $past(file_rdata))) else $error("move wrong");
    chk_acc_store: assert property (ex && (w & 14'h3F80) == 14'h0080 |=>
        file_we && file_wdata == $past(working_accumulator)
        && $stable(zero_flag)) else $error("store wrong");
    chk_load_option: assert property (ex && w == 14'h0062 |=>
        option_config == $past(working_accumulator) && $stable(zero_flag))
        else $error("option load wrong");
    chk_nop_idle: assert property (ex && (w & 14'h3F9F) == 14'h0000 |=>
        !file_we && !flushing && $stable(working_accumulator)
        && $stable(zero_flag)
        && program_counter == $past(program_counter) + 13'h1)
        else $error("nop wrong");
endmodule
bind pie_core pie_core_monitor chk_u (.*);
`default_nettype wire

// [test/tb_partial_instruction_executor.sv]
// Random instruction mix against a reference state model.
// Assumes the bench plays the fetch path and the file register array.
`timescale 1ns/10ps
`default_nettype none
module tb_partial_instruction_executor;
    logic        sys_clk, reset, insn_valid, irq_request, zero_flag;
    logic        file_we, flushing, z;
    logic [13:0] insn_word, wd;
    logic [7:0]  program_counter_high_latch, file_wdata, acc, opt;
    logic [7:0]  working_accumulator, option_config, rf [128];
    logic [6:0]  file_addr;
    logic [12:0] program_counter, stack_top, pc, ret;
    logic [31:0] r;
    logic [59:0] notes [$];
    int          bad_count, checks_done, seed, i;
    wire logic [7:0] file_rdata = rf[insn_word[6:0]];
    wire logic [59:0] seen = {program_counter, working_accumulator,
        zero_flag, option_config, stack_top, flushing, file_we,
        file_we ? file_addr : 7'h00, file_we ? file_wdata : 8'h00};
    pie_core dut_u (.*);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Writes land one edge late, so the word right after a write does not see it.
    always @(posedge sys_clk) if (file_we === 1'b1) rf[file_addr] <= file_wdata;
    task automatic cmp(input logic [59:0] e, input logic [59:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    always @(posedge sys_clk) begin
        #2;
        if (notes.size() > 0)
            cmp(notes.pop_front(), seen);
    end
    task automatic step(input logic irq);
        logic [7:0] v, dv;
        logic       fl, we;
        #1;
        v = rf[wd[6:0]];
        we = !irq && (wd[13:7] == 7'h03 || wd[13:7] == 7'h01 ||
             (wd[13:8] == 6'h08 && wd[7]));
        dv = wd[13:7] == 7'h01 ? acc : (wd[13:7] == 7'h03 ? 8'h00 : v);
        insn_word = wd;
        irq_request = irq;
        insn_valid = 1'b1;
        program_counter_high_latch = r[31:24];
        fl = irq || wd[13:11] == 3'b100 || (wd[13:10] == 4'h7 && v[wd[9:7]]);
        if (irq) begin
            ret = pc;
            pc = 13'h0004;
        end else if (wd[13:11] == 3'b100) begin
            ret = pc + 13'h1;
            pc = {r[28:27], wd[10:0]};
        end else begin
            pc = pc + 13'h1;
            if (wd[13:7] == 7'h03) z = 1'b1;
            if (wd[13:8] == 6'h08) z = v == 8'h00;
            if (wd[13:7] == 7'h10) acc = v;
            if (wd == 14'h0062) opt = acc;
        end
        @(posedge sys_clk);
        notes.push_back({pc, acc, z, opt, ret, fl, we,
                         we ? wd[6:0] : 7'h00, we ? dv : 8'h00});
        if (fl) begin
            #1;
            insn_word = 14'($random(seed));
            irq_request = 1'b0;
            pc = pc + 13'h1;
            @(posedge sys_clk);
            notes.push_back({pc, acc, z, opt, ret, 17'h00000});
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d in %0d checks", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        seed = 66;
        {reset, insn_valid, irq_request, z, acc, opt} = {4'hA, 8'h00, 8'hFF};
        {insn_word, program_counter_high_latch, pc, ret, r} = '0;
        for (i = 0; i < 128; i++) rf[i] = 8'($random(seed));
        repeat (5) @(posedge sys_clk);
        cmp({22'h000000, 8'hFF, 13'h0000, 17'h00000}, seen);
        #1 reset = 1'b0;
        for (i = 0; i < 400; i++) begin
            r = $random(seed);
            case (r[17:15])
                3'd0: wd = {4'h7, r[9:0]};
                3'd1: wd = {3'b100, r[10:0]};
                3'd2: wd = {7'h03, r[6:0]};
                3'd3: wd = {6'h08, r[7:0]};
                3'd4: wd = {7'h01, r[6:0]};
                3'd5: wd = 14'h0062;
                3'd6: wd = {7'h00, r[1:0], 5'h00};
                default: wd = r[13:0];
            endcase
            step(r[19] & r[20]);
        end
        repeat (2) @(posedge sys_clk);
        test_done;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        test_done;
    end
endmodule
`default_nettype wire
